/* tbc_pkg.sv */
// Package with register map, field layout and carrier types for the 10M/self-test slice
package tbc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] TBC_ADDR_TEN_CTRL   = 5'h1a;
  localparam logic [4:0] TBC_ADDR_ERR_GAP    = 5'h1b;
  localparam logic [4:0] TBC_ADDR_PKT_LEN    = 5'h1c;
  localparam logic [4:0] TBC_ADDR_PHY_STATUS = 5'h10;
  localparam logic [4:0] TBC_ADDR_IRQ_STAT   = 5'h08;
  localparam logic [4:0] TBC_ADDR_IRQ_MASK   = 5'h09;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int TBC_BIT_RX_THRESH_LOW = 13;
  localparam int TBC_SQ_LSB            = 9;
  localparam int TBC_BIT_LP_SUPPRESS   = 7;
  localparam int TBC_BIT_POLARITY      = 4;
  localparam int TBC_BIT_JABBER_OFF    = 0;
  localparam int TBC_BIT_STS_POLARITY  = 12;
  localparam int TBC_BIT_LATCH_CMD     = 15;
  localparam int TBC_ERR_LSB           = 8;
  localparam logic [7:0]  TBC_GAP_RESET     = 8'h7d;
  localparam logic [10:0] TBC_PKT_LEN_RESET = 11'h5ee;
  localparam logic [7:0]  TBC_ERR_MAX       = 8'hff;
  localparam logic [15:0] TBC_TEN_WMASK     = 16'h3e81;

  // Squelch threshold figures in millivolts, and bytes per gap quad
  localparam int TBC_SQ_BASE_MV = 200;
  localparam int TBC_SQ_STEP_MV = 50;
  localparam int TBC_GAP_UNIT   = 4;

  // Interrupt status bit positions
  localparam int TBC_IRQ_POLARITY = 0;
  localparam int TBC_IRQ_ERRBYTE  = 1;
  localparam int TBC_IRQ_SAT      = 2;
  localparam int TBC_IRQ_W        = 3;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tbc_bus_req_t;

  typedef struct packed {
    logic        rx_thresh_low;
    logic [3:0]  squelch_code;
    logic        link_pulse_suppress;
    logic        jabber_off;
    logic [7:0]  selftest_gap_quads;
    logic [10:0] selftest_pkt_bytes;
  } tbc_cfg_t;

  typedef struct packed {
    logic        polarity_inv;
    logic        prbs_err_byte;
    logic        err_cnt_wrap;
    logic        speed_10m;
  } tbc_evt_t;

endpackage

/* tbc_cnt.sv */
// Errored-byte counter with latch-and-clear and saturate or wrap mode
`timescale 1ns/1ns
module tbc_cnt #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         err_byte,
  input  wire logic         wrap_mode,
  input  wire logic         latch_clr,
  output logic [W-1:0]      held_count,
  output logic              saturated
);

  typedef struct packed {
    logic [W-1:0] run;
    logic [W-1:0] held;
    logic         sat;
  } tbc_cnt_state_t;

  tbc_cnt_state_t st_reg;
  tbc_cnt_state_t st_next;

  // Count, latch and clear; a latch in the same cycle as an error drops that byte
  always_comb begin
    st_next     = st_reg;
    st_next.sat = 1'b0;
    if (latch_clr) begin
      st_next.held = st_reg.run;
      st_next.run  = '0;
    end else if (err_byte) begin
      if (st_reg.run == {W{1'b1}} && !wrap_mode) begin
        st_next.sat = 1'b1;
      end else begin
        st_next.run = st_reg.run + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign held_count = st_reg.held;
  assign saturated  = st_reg.sat;

endmodule

/* tbc_regs.sv */
// 10 Mb/s control and self-test configuration registers with interrupt logic
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
module tbc_regs #(
  parameter int ERR_W = 8
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire tbc_pkg::tbc_bus_req_t bus_req,
  output logic [15:0]               rd_data,
  input  wire logic                 pol_inv_pin,
  input  wire logic                 err_byte,
  input  wire logic                 err_cnt_wrap,
  input  wire logic                 speed_10m,
  output tbc_pkg::tbc_cfg_t         cfg,
  output logic                      jabber_active_off,
  output logic [9:0]                selftest_gap_bytes,
  output logic [9:0]                squelch_mv,
  output logic                      irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                           pol_s1;
    logic                           pol_s2;
    logic                           pol_s3;
    logic                           pol_flag;
    tbc_pkg::tbc_cfg_t              cfg;
    logic [15:0]                    rd_data;
    logic [tbc_pkg::TBC_IRQ_W-1:0]  stat;
    logic [tbc_pkg::TBC_IRQ_W-1:0]  mask;
    logic                           irq;
    logic                           jab_off;
    logic [9:0]                     gap_bytes;
    logic [9:0]                     sq_mv;
    logic                           lat_pend;
  } tbc_state_t;

  tbc_state_t st_reg;
  tbc_state_t st_next;

  logic [ERR_W-1:0] held_count;
  logic             saturated;
  logic             latch_clr;
  logic             wr_ten;
  logic             wr_gap;
  logic             wr_len;
  logic             rd_ten;
  logic [tbc_pkg::TBC_IRQ_W-1:0] evt;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign wr_ten    = bus_req.wr && bus_req.addr == tbc_pkg::TBC_ADDR_TEN_CTRL;
  assign wr_gap    = bus_req.wr && bus_req.addr == tbc_pkg::TBC_ADDR_ERR_GAP;
  assign wr_len    = bus_req.wr && bus_req.addr == tbc_pkg::TBC_ADDR_PKT_LEN;
  assign rd_ten    = bus_req.rd && bus_req.addr == tbc_pkg::TBC_ADDR_TEN_CTRL;
  assign latch_clr = wr_gap && bus_req.wdata[tbc_pkg::TBC_BIT_LATCH_CMD];

  // Error counter lives apart so its width can change
  tbc_cnt #(
    .W (ERR_W)
  ) u_cnt (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .err_byte   (err_byte),
    .wrap_mode  (err_cnt_wrap),
    .latch_clr  (latch_clr),
    .held_count (held_count),
    .saturated  (saturated)
  );

  // Event vector for sticky status
  always_comb begin
    evt = '0;
    evt[tbc_pkg::TBC_IRQ_POLARITY] = st_reg.pol_s3 & ~st_reg.pol_flag;
    evt[tbc_pkg::TBC_IRQ_ERRBYTE]  = err_byte;
    evt[tbc_pkg::TBC_IRQ_SAT]      = saturated;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next         = st_reg;
    // Three flops on the analog polarity detector before any logic
    st_next.pol_s1  = pol_inv_pin;
    st_next.pol_s2  = st_reg.pol_s1;
    st_next.pol_s3  = st_reg.pol_s2;
    st_next.rd_data = 16'h0000;
    st_next.lat_pend = 1'b0;

    // Polarity flag: set wins over the read clear so no detection is lost
    if (rd_ten) begin
      st_next.pol_flag = 1'b0;
    end
    if (st_reg.pol_s3) begin
      st_next.pol_flag = 1'b1;
    end

    // Register writes; reserved bits never stored
    if (wr_ten) begin
      st_next.cfg.rx_thresh_low = bus_req.wdata[tbc_pkg::TBC_BIT_RX_THRESH_LOW];
      st_next.cfg.squelch_code  = bus_req.wdata[tbc_pkg::TBC_SQ_LSB +: 4];
      st_next.cfg.link_pulse_suppress = bus_req.wdata[tbc_pkg::TBC_BIT_LP_SUPPRESS];
      st_next.cfg.jabber_off    = bus_req.wdata[tbc_pkg::TBC_BIT_JABBER_OFF];
    end
    if (wr_gap) begin
      st_next.cfg.selftest_gap_quads = bus_req.wdata[7:0];
    end
    if (wr_len) begin
      st_next.cfg.selftest_pkt_bytes = bus_req.wdata[10:0];
    end
    if (bus_req.wr && bus_req.addr == tbc_pkg::TBC_ADDR_IRQ_MASK) begin
      st_next.mask = bus_req.wdata[tbc_pkg::TBC_IRQ_W-1:0];
    end

    // Sticky status: write one clears, a new event wins
    if (bus_req.wr && bus_req.addr == tbc_pkg::TBC_ADDR_IRQ_STAT) begin
      st_next.stat = st_reg.stat & ~bus_req.wdata[tbc_pkg::TBC_IRQ_W-1:0];
    end
    st_next.stat = st_next.stat | evt;
    st_next.irq  = |(st_reg.stat & st_reg.mask);

    // Read mux; unmapped addresses read zero, reserved bits zero
    if (bus_req.rd) begin
      case (bus_req.addr)
        tbc_pkg::TBC_ADDR_TEN_CTRL: begin
          st_next.rd_data[tbc_pkg::TBC_BIT_RX_THRESH_LOW] = st_reg.cfg.rx_thresh_low;
          st_next.rd_data[tbc_pkg::TBC_SQ_LSB +: 4]  = st_reg.cfg.squelch_code;
          st_next.rd_data[tbc_pkg::TBC_BIT_LP_SUPPRESS] = st_reg.cfg.link_pulse_suppress;
          st_next.rd_data[tbc_pkg::TBC_BIT_POLARITY] = st_reg.pol_flag;
          st_next.rd_data[tbc_pkg::TBC_BIT_JABBER_OFF] = st_reg.cfg.jabber_off;
        end
        tbc_pkg::TBC_ADDR_ERR_GAP: begin
          st_next.rd_data[tbc_pkg::TBC_ERR_LSB +: 8] = held_count[7:0];
          st_next.rd_data[7:0] = st_reg.cfg.selftest_gap_quads;
        end
        tbc_pkg::TBC_ADDR_PKT_LEN: begin
          st_next.rd_data[10:0] = st_reg.cfg.selftest_pkt_bytes;
        end
        tbc_pkg::TBC_ADDR_PHY_STATUS: begin
          // Status read shows the copy without clearing it
          st_next.rd_data[tbc_pkg::TBC_BIT_STS_POLARITY] = st_reg.pol_flag;
        end
        tbc_pkg::TBC_ADDR_IRQ_STAT: begin
          st_next.rd_data[tbc_pkg::TBC_IRQ_W-1:0] = st_reg.stat;
        end
        tbc_pkg::TBC_ADDR_IRQ_MASK: begin
          st_next.rd_data[tbc_pkg::TBC_IRQ_W-1:0] = st_reg.mask;
        end
        default: begin
          st_next.rd_data = 16'h0000;
        end
      endcase
    end

    // Derived controls; jabber disable only honoured at 10 Mb/s
    st_next.jab_off   = st_reg.cfg.jabber_off & speed_10m;
    st_next.gap_bytes = {st_reg.cfg.selftest_gap_quads, 2'b00};
    st_next.sq_mv     = 10'(tbc_pkg::TBC_SQ_BASE_MV
                        + tbc_pkg::TBC_SQ_STEP_MV * int'(st_reg.cfg.squelch_code));
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg                        <= '0;
      st_reg.cfg.selftest_gap_quads <= tbc_pkg::TBC_GAP_RESET;
      st_reg.cfg.selftest_pkt_bytes <= tbc_pkg::TBC_PKT_LEN_RESET;
      st_reg.gap_bytes              <= {tbc_pkg::TBC_GAP_RESET, 2'b00};
      st_reg.sq_mv                  <= 10'(tbc_pkg::TBC_SQ_BASE_MV);
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign rd_data            = st_reg.rd_data;
  assign cfg                = st_reg.cfg;
  assign jabber_active_off  = st_reg.jab_off;
  assign selftest_gap_bytes = st_reg.gap_bytes;
  assign squelch_mv         = st_reg.sq_mv;
  assign irq                = st_reg.irq;

endmodule

/* tbc_regs_assertions.sv */
// Port-level assertions for the 10 Mb/s and self-test register slice
`timescale 1ns/1ns
module tbc_regs_chk (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire tbc_pkg::tbc_bus_req_t bus_req,
  input wire logic [15:0]           rd_data,
  input wire tbc_pkg::tbc_cfg_t     cfg,
  input wire logic                  speed_10m,
  input wire logic                  jabber_active_off,
  input wire logic [9:0]            selftest_gap_bytes,
  input wire logic [9:0]            squelch_mv,
  input wire logic                  irq
);
  // ----------------------------------------------------------------
  // Single domain, reset masks every check
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rd_idle; !bus_req.rd |=> rd_data == 16'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_rsv; bus_req.rd && bus_req.addr == tbc_pkg::TBC_ADDR_TEN_CTRL
    |=> (rd_data & 16'hc16e) == 16'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved control bit set");
  property p_ctl_wr; bus_req.wr && bus_req.addr == tbc_pkg::TBC_ADDR_TEN_CTRL
    |=> cfg.rx_thresh_low == $past(bus_req.wdata[13])
    && cfg.squelch_code == $past(bus_req.wdata[12:9]); endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("threshold or squelch");
  property p_lp_wr; bus_req.wr && bus_req.addr == tbc_pkg::TBC_ADDR_TEN_CTRL
    |=> cfg.link_pulse_suppress == $past(bus_req.wdata[7])
    && cfg.jabber_off == $past(bus_req.wdata[0]); endproperty
  a_lp_wr: assert property (p_lp_wr) else $error("link pulse or jabber");
  property p_gap_wr; bus_req.wr && bus_req.addr == tbc_pkg::TBC_ADDR_ERR_GAP
    |=> cfg.selftest_gap_quads == $past(bus_req.wdata[7:0]); endproperty
  a_gap_wr: assert property (p_gap_wr) else $error("gap field");
  property p_len_wr; bus_req.wr && bus_req.addr == tbc_pkg::TBC_ADDR_PKT_LEN
    |=> cfg.selftest_pkt_bytes == $past(bus_req.wdata[10:0]); endproperty
  a_len_wr: assert property (p_len_wr) else $error("length field");
  property p_sq; 1'b1 |-> squelch_mv == 10'd200 + 10'd50 * {6'h0, $past(cfg.squelch_code)};
  endproperty
  a_sq: assert property (p_sq) else $error("squelch level");
  // Both directions: the disable must follow the speed as well as the bit
  property p_jab; 1'b1 |-> jabber_active_off == $past(cfg.jabber_off && speed_10m); endproperty
  a_jab: assert property (p_jab) else $error("jabber not off");
  property p_gapb; 1'b1 |-> selftest_gap_bytes == {$past(cfg.selftest_gap_quads), 2'b00};
  endproperty
  a_gapb: assert property (p_gapb) else $error("gap in bytes");
  // Mask cleared: irq must be low two edges later, whatever is pending
  property p_irq_off; bus_req.wr && bus_req.addr == tbc_pkg::TBC_ADDR_IRQ_MASK
    && bus_req.wdata[2:0] == 3'h0 |-> ##2 !irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with mask clear");
  // Covers for the main traffic
  c_pol: cover property (bus_req.rd && bus_req.addr == tbc_pkg::TBC_ADDR_TEN_CTRL ##1 rd_data[4]);
  c_jab: cover property (jabber_active_off);
  c_len: cover property (bus_req.wr && bus_req.addr == tbc_pkg::TBC_ADDR_PKT_LEN);
endmodule
bind tbc_regs tbc_regs_chk tbc_regs_chk_inst (.clk_sys, .rst, .bus_req, .rd_data, .cfg,
  .speed_10m, .jabber_active_off, .selftest_gap_bytes, .squelch_mv, .irq);

/* tb_top.sv */
// Self-checking bench for the 10 Mb/s and self-test register slice
`timescale 1ns/1ns
module tb_top;
  logic                  clk_sys, rst, pol_inv_pin, err_byte, err_cnt_wrap, speed_10m, jab, irq;
  tbc_pkg::tbc_bus_req_t bus_req;
  tbc_pkg::tbc_cfg_t     cfg;
  logic [15:0]           rd_data, rdv;
  logic [9:0]            gap_b, sq_mv;
  logic [31:0]           seed, rv;
  int                    n_fail, n_checks, m_ctrl, m_gap, m_len, m_cnt, m_held, m_pol;
  int                    m_stat, m_mask;
  logic [4:0]            regs [5] = '{5'h1a, 5'h1b, 5'h1c, 5'h10, 5'h1f};
  tbc_regs tbc_regs_inst (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .pol_inv_pin(pol_inv_pin), .err_byte(err_byte), .err_cnt_wrap(err_cnt_wrap),
    .speed_10m(speed_10m), .cfg(cfg), .jabber_active_off(jab), .selftest_gap_bytes(gap_b),
    .squelch_mv(sq_mv), .irq(irq));
  // ----------------------------------------------------------------
  // Clock, helpers and bus tasks
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Model read view; polarity flag is one copy shared by both addresses
  function automatic int exp_rd(input logic [4:0] a);
    case (a)
      tbc_pkg::TBC_ADDR_TEN_CTRL: return m_ctrl | (m_pol << 4);
      tbc_pkg::TBC_ADDR_ERR_GAP: return (m_held << 8) | m_gap;
      tbc_pkg::TBC_ADDR_PKT_LEN: return m_len;
      tbc_pkg::TBC_ADDR_PHY_STATUS: return m_pol << 12;
      tbc_pkg::TBC_ADDR_IRQ_STAT: return m_stat;
      tbc_pkg::TBC_ADDR_IRQ_MASK: return m_mask;
      default: return 0;
    endcase
  endfunction
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    if (a == tbc_pkg::TBC_ADDR_TEN_CTRL) m_ctrl = d & 16'h3e81;
    if (a == tbc_pkg::TBC_ADDR_PKT_LEN) m_len = d[10:0];
    if (a == tbc_pkg::TBC_ADDR_ERR_GAP) m_gap = d[7:0];
    if (a == tbc_pkg::TBC_ADDR_ERR_GAP && d[15]) m_held = m_cnt;
    if (a == tbc_pkg::TBC_ADDR_ERR_GAP && d[15]) m_cnt = 0;
    if (a == tbc_pkg::TBC_ADDR_IRQ_MASK) m_mask = d[2:0];
    if (a == tbc_pkg::TBC_ADDR_IRQ_STAT) m_stat = m_stat & ~int'(d[2:0]);
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk_sys);
    bus_req <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 rdv = rd_data;
    chk(rdv, 16'(exp_rd(a)));
    if (a == tbc_pkg::TBC_ADDR_TEN_CTRL) m_pol = 0;
  endtask
  // Back-to-back error bytes; saturation unless wrap mode is on
  task automatic errs(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      err_byte <= 1'b1;
      // Error event always; saturation event only when a full count is hit again
      m_stat = m_stat | 2 | ((!err_cnt_wrap && m_cnt == 255) ? 4 : 0);
      m_cnt = err_cnt_wrap ? (m_cnt + 1) % 256 : (m_cnt < 255 ? m_cnt + 1 : 255);
    end
    @(posedge clk_sys);
    err_byte <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 850 cycles
  initial begin
    repeat (6000) @(posedge clk_sys);
    n_fail++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {seed, m_gap, m_len} = {32'd49129, 32'h7d, 32'h5ee};
    {m_ctrl, m_cnt, m_held, m_pol, m_stat, m_mask} = '0;
    {bus_req, pol_inv_pin, err_byte, err_cnt_wrap, speed_10m, rst} = '0 | 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk(gap_b, 16'd500);
    chk(sq_mv, 16'd200);
    foreach (regs[i]) rd(regs[i]);
    $display("reset test done");
    for (int c = 0; c <= 8; c++) begin
      wr(tbc_pkg::TBC_ADDR_TEN_CTRL, 16'(c << 9) | 16'hc16e);
      repeat (2) @(posedge clk_sys);
      #1 chk(sq_mv, 16'(200 + 50 * c));
      rd(tbc_pkg::TBC_ADDR_TEN_CTRL);
    end
    $display("squelch test done");
    repeat (8) begin
      rv = xs();
      @(posedge clk_sys);
      speed_10m <= rv[16];
      wr(tbc_pkg::TBC_ADDR_TEN_CTRL, rv[15:0]);
      wr(tbc_pkg::TBC_ADDR_PKT_LEN, rv[31:16]);
      wr(tbc_pkg::TBC_ADDR_ERR_GAP, {1'b0, rv[22:8]});
      @(posedge clk_sys);
      #1 chk({cfg.rx_thresh_low, cfg.link_pulse_suppress}, {rv[13], rv[7]});
      chk(jab, rv[0] & rv[16]);
      chk(gap_b, {rv[15:8], 2'b00});
      foreach (regs[i]) rd(regs[i]);
    end
    $display("config test done");
    @(posedge clk_sys);
    pol_inv_pin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    pol_inv_pin <= 1'b0;
    repeat (5) @(posedge clk_sys);
    m_pol = 1;
    m_stat = m_stat | 1;
    rd(tbc_pkg::TBC_ADDR_PHY_STATUS);
    rd(tbc_pkg::TBC_ADDR_PHY_STATUS);
    rd(tbc_pkg::TBC_ADDR_TEN_CTRL);
    rd(tbc_pkg::TBC_ADDR_TEN_CTRL);
    rd(tbc_pkg::TBC_ADDR_PHY_STATUS);
    $display("polarity test done");
    // Small count, saturation past 0xff, then wrap past 0xff
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      err_cnt_wrap <= (k == 2);
      errs(k == 0 ? 5 : (k == 1 ? 300 : 260));
      wr(tbc_pkg::TBC_ADDR_ERR_GAP, 16'h8000 | 16'(m_gap));
      rd(tbc_pkg::TBC_ADDR_ERR_GAP);
    end
    $display("counter test done");
    #1 chk(irq, 1'b0);
    wr(tbc_pkg::TBC_ADDR_IRQ_MASK, 16'h0007);
    repeat (2) @(posedge clk_sys);
    #1 chk(irq, 1'b1);
    rd(tbc_pkg::TBC_ADDR_IRQ_STAT);
    rd(tbc_pkg::TBC_ADDR_IRQ_MASK);
    wr(tbc_pkg::TBC_ADDR_IRQ_STAT, 16'h0007);
    repeat (2) @(posedge clk_sys);
    #1 chk(irq, 1'b0);
    errs(1);
    repeat (2) @(posedge clk_sys);
    #1 chk(irq, 1'b1);
    rd(tbc_pkg::TBC_ADDR_IRQ_STAT);
    wr(tbc_pkg::TBC_ADDR_IRQ_MASK, 16'h0000);
    repeat (2) @(posedge clk_sys);
    #1 chk(irq, 1'b0);
    $display("interrupt test done");
    end_sim();
  end
endmodule
